// ### design/spsf_pkg.sv
package spsf_pkg;

  // port numbering inside arrays
  localparam int unsigned NPORTS = 2;
  localparam int unsigned P232   = 0;
  localparam int unsigned P422   = 1;

  // register indices; the byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_422_STATUS  = 10'h13e;
  localparam logic [9:0] IDX_422_COUNT   = 10'h13f;
  localparam logic [9:0] IDX_232_STATUS  = 10'h188;
  localparam logic [9:0] IDX_232_COUNT   = 10'h189;
  localparam logic [9:0] IDX_RESTART     = 10'h20e;
  localparam logic [9:0] IDX_ERR_CODES   = 10'h210;
  localparam logic [9:0] IDX_SETTINGS    = 10'h26b;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h300;
  localparam logic [9:0] IDX_IRQ_CLEAR   = 10'h301;
  localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h302;

  // field positions
  localparam int unsigned ERR_LO       = 2;
  localparam int unsigned B232_COMM    = 4;
  localparam int unsigned B232_SEND    = 5;
  localparam int unsigned B232_RXDONE  = 6;
  localparam int unsigned B232_OVF     = 7;
  localparam int unsigned B422_COMM    = 8;
  localparam int unsigned B422_SEND    = 9;
  localparam int unsigned B422_RXDONE  = 10;
  localparam int unsigned B422_OVF     = 11;
  localparam int unsigned B422_BUSY    = 15;
  localparam int unsigned B232_BUSY    = 2;
  localparam int unsigned B232_RESTART = 0;
  localparam int unsigned B422_RESTART = 7;

  // interrupt event layout, four per port
  localparam int unsigned IRQ_PER_PORT = 4;
  localparam int unsigned IRQ_COMM     = 0;
  localparam int unsigned IRQ_RXDONE   = 1;
  localparam int unsigned IRQ_OVF      = 2;
  localparam int unsigned IRQ_RESTART  = 3;

  // values after reset
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0]  IRQ_RST   = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // events and levels from one serial port engine
  typedef struct packed {
    logic [3:0] err;          // error flag pulses
    logic       comm_err;     // pulse
    logic       send_ready;   // level
    logic       rx_done;      // pulse
    logic       overflow;     // pulse
    logic       rx_byte;      // pulse per received byte
    logic       settings_busy; // level
    logic       restart_done; // pulse
  } spsf_evt_t;

  // reported state of one port
  typedef struct packed {
    logic [3:0]  err;
    logic        comm_err;
    logic        send_ready;
    logic        rx_done;
    logic        overflow;
    logic        settings_busy;
    logic [15:0] count;
    logic        restart;
  } spsf_stat_t;

endpackage

// ### design/spsf_port.sv
`timescale 1ns/1ns
module spsf_port
  import spsf_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       raw_mode,
  input  wire logic       restart_set,
  // port engine
  input  wire spsf_evt_t  evt,
  // status
  output spsf_stat_t      stat
);

  spsf_stat_t next_stat;
  logic       done_eff;

  // completion only counts while a restart is pending
  assign done_eff = stat.restart & evt.restart_done;

  // sticky flags cleared by a finished restart; a new event wins
  always_comb begin
    next_stat = stat;
    next_stat.err = (done_eff ? 4'h0 : stat.err) | evt.err;
    next_stat.comm_err = (stat.comm_err & ~done_eff)
                       | evt.comm_err;
    next_stat.send_ready = raw_mode & evt.send_ready;
    next_stat.rx_done = (stat.rx_done & ~done_eff)
                      | (raw_mode & evt.rx_done);
    next_stat.overflow = (stat.overflow & ~done_eff)
                       | (raw_mode & evt.overflow);
    next_stat.settings_busy = evt.settings_busy;
    if (done_eff) begin
      next_stat.count = COUNT_RST;
    end
    if (raw_mode && evt.rx_byte) begin
      next_stat.count = next_stat.count + 16'h0001;
    end
    // a fresh request wins over completion
    next_stat.restart = restart_set
                      | (stat.restart & ~done_eff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_err_field: assert property ((|evt.err) |=>
    ((stat.err & $past(evt.err)) == $past(evt.err)))
    else $error("error field missed an event");
  a_comm_err: assert property (evt.comm_err |=> stat.comm_err)
    else $error("comm error flag not set");
  a_send_ready: assert property (##1
    stat.send_ready == $past(raw_mode && evt.send_ready))
    else $error("send ready wrong");
  a_rx_done: assert property (raw_mode && evt.rx_done |=>
    stat.rx_done) else $error("rx done not set");
  a_overflow: assert property (raw_mode && evt.overflow |=>
    stat.overflow) else $error("overflow not set");
  a_settings_busy: assert property (##1
    stat.settings_busy == $past(evt.settings_busy))
    else $error("settings busy wrong");
  a_byte_count: assert property (raw_mode && evt.rx_byte && !done_eff
    |=> stat.count == $past(stat.count) + 16'h0001)
    else $error("byte count not advanced");
  a_restart_clear: assert property ($fell(stat.restart) |->
    $past(evt.restart_done)) else $error("restart cleared early");
  c_restart_done: cover property (stat.restart ##[1:20] !stat.restart);

endmodule // spsf_port

// ### design/spsf_regs.sv
`timescale 1ns/1ns
module spsf_regs
  import spsf_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // serial port engines
  input  wire spsf_evt_t         evt_232,
  input  wire spsf_evt_t         evt_422,
  input  wire logic              terminal_link_mode,
  input  wire logic [7:0]        term_active,
  input  wire logic              term_prio_valid,
  input  wire logic [2:0]        term_prio_unit,
  // restart requests to the engines
  output logic [NPORTS-1:0]      restart_req,
  // interrupt
  output logic                   irq
);

  spsf_evt_t         evt [NPORTS];
  spsf_stat_t        stat [NPORTS];
  logic [NPORTS-1:0] raw_mode;
  logic [NPORTS-1:0] restart_set;
  logic [7:0]        prio_onehot;
  logic [7:0]        irq_event;

  assign evt[P232] = evt_232;
  assign evt[P422] = evt_422;
  // the RS-422A port has no terminal link mode
  assign raw_mode[P232] = ~terminal_link_mode;
  assign raw_mode[P422] = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // per-port status logic
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    spsf_port u_port (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .raw_mode    (raw_mode[p]),
      .restart_set (restart_set[p]),
      .evt         (evt[p]),
      .stat        (stat[p])
    );
    assign restart_req[p] = stat[p].restart;
    // interrupt sources of this port
    assign irq_event[p*IRQ_PER_PORT+IRQ_COMM] = evt[p].comm_err;
    assign irq_event[p*IRQ_PER_PORT+IRQ_RXDONE] =
      raw_mode[p] & evt[p].rx_done;
    assign irq_event[p*IRQ_PER_PORT+IRQ_OVF] =
      raw_mode[p] & evt[p].overflow;
    assign irq_event[p*IRQ_PER_PORT+IRQ_RESTART] =
      stat[p].restart & evt[p].restart_done;
  end

  // priority unit index to a single set bit
  for (genvar u = 0; u < 8; u++) begin : g_prio
    assign prio_onehot[u] = term_prio_valid
                          && (term_prio_unit == 3'(u));
  end

  ////////////////////////////////////////////////////////////////////////
  // rs-232c counter word, registered so it can be read stable
  logic [15:0] cnt232_word;
  logic [15:0] next_cnt232_word;

  always_comb begin
    if (terminal_link_mode) begin
      next_cnt232_word = {prio_onehot, term_active};
    end else begin
      next_cnt232_word = stat[P232].count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt232_word <= COUNT_RST;
    end else begin
      cnt232_word <= next_cnt232_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data are held until both are here
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_en;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic [9:0]        wr_idx;
  logic              wr_hit;

  assign awready = ~aw_held;
  assign wready  = ~w_held;
  // one write at a time: commit only once the last answer is gone
  assign wr_en   = aw_held & w_held & ~bvalid;
  assign wr_idx  = aw_addr[ADDR_W-1:2];
  assign wr_hit  = (wr_idx == IDX_422_STATUS) || (wr_idx == IDX_422_COUNT)
                || (wr_idx == IDX_232_STATUS) || (wr_idx == IDX_232_COUNT)
                || (wr_idx == IDX_RESTART) || (wr_idx == IDX_ERR_CODES)
                || (wr_idx == IDX_SETTINGS) || (wr_idx == IDX_IRQ_STATUS)
                || (wr_idx == IDX_IRQ_CLEAR) || (wr_idx == IDX_IRQ_ENABLE);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_en) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // restart bits live in byte lane 0; writing zero has no effect
  assign restart_set[P232] = wr_en && (wr_idx == IDX_RESTART)
    && w_strb[0] && w_data[B232_RESTART];
  assign restart_set[P422] = wr_en && (wr_idx == IDX_RESTART)
    && w_strb[0] && w_data[B422_RESTART];

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and write-one-to-clear
  logic [7:0] irq_status;
  logic [7:0] irq_enable;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_enable;
  logic [7:0] irq_clr;

  assign irq_clr = (wr_en && (wr_idx == IDX_IRQ_CLEAR) && w_strb[0])
                 ? w_data[7:0] : 8'h00;

  always_comb begin
    // an event in the clearing cycle is kept
    next_irq_status = (irq_status & ~irq_clr) | irq_event;
    next_irq_enable = irq_enable;
    if (wr_en && (wr_idx == IDX_IRQ_ENABLE) && w_strb[0]) begin
      next_irq_enable = w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= IRQ_RST;
      irq_enable <= IRQ_RST;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////
  // word images of the documented registers
  logic [15:0] w422_status;
  logic [15:0] w232_status;
  logic [15:0] w_restart;
  logic [15:0] w_err_codes;
  logic [15:0] w_settings;

  always_comb begin
    w422_status = 16'h0000;
    w422_status[ERR_LO +: 4]  = stat[P422].err;
    w422_status[B422_COMM]    = stat[P422].comm_err;
    w422_status[B422_SEND]    = stat[P422].send_ready;
    w422_status[B422_RXDONE]  = stat[P422].rx_done;
    w422_status[B422_OVF]     = stat[P422].overflow;
    w422_status[B422_BUSY]    = stat[P422].settings_busy;
    w232_status = 16'h0000;
    w232_status[B232_COMM]    = stat[P232].comm_err;
    w232_status[B232_SEND]    = stat[P232].send_ready;
    w232_status[B232_RXDONE]  = stat[P232].rx_done;
    w232_status[B232_OVF]     = stat[P232].overflow;
    w_restart = 16'h0000;
    w_restart[B232_RESTART]   = stat[P232].restart;
    w_restart[B422_RESTART]   = stat[P422].restart;
    w_err_codes = 16'h0000;
    w_err_codes[ERR_LO +: 4]  = stat[P232].err;
    w_settings = 16'h0000;
    w_settings[B232_BUSY]     = stat[P232].settings_busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after the address is taken
  logic [9:0]  rd_idx;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;

  assign arready = ~rvalid;
  assign rd_idx  = araddr[ADDR_W-1:2];

  // reads have no side effects; unmapped words answer an error
  always_comb begin
    rd_mux  = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (rd_idx == IDX_422_STATUS) begin
      rd_mux = {16'h0000, w422_status};
    end else if (rd_idx == IDX_422_COUNT) begin
      rd_mux = {16'h0000, stat[P422].count};
    end else if (rd_idx == IDX_232_STATUS) begin
      rd_mux = {16'h0000, w232_status};
    end else if (rd_idx == IDX_232_COUNT) begin
      rd_mux = {16'h0000, cnt232_word};
    end else if (rd_idx == IDX_RESTART) begin
      rd_mux = {16'h0000, w_restart};
    end else if (rd_idx == IDX_ERR_CODES) begin
      rd_mux = {16'h0000, w_err_codes};
    end else if (rd_idx == IDX_SETTINGS) begin
      rd_mux = {16'h0000, w_settings};
    end else if (rd_idx == IDX_IRQ_STATUS) begin
      rd_mux = {24'h00_0000, irq_status};
    end else if (rd_idx == IDX_IRQ_CLEAR) begin
      rd_mux = 32'h0000_0000;                  // write-only
    end else if (rd_idx == IDX_IRQ_ENABLE) begin
      rd_mux = {24'h00_0000, irq_enable};
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_comb begin
    next_rdata  = rdata;
    next_rresp  = rresp;
    next_rvalid = rvalid;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rdata  = rd_mux;
      next_rresp  = rd_resp;
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rresp  <= next_rresp;
      rvalid <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_term_active: assert property (terminal_link_mode |=>
    cnt232_word[7:0] == $past(term_active))
    else $error("terminal activity byte wrong");
  a_term_prio: assert property (terminal_link_mode && term_prio_valid
    |=> cnt232_word[8 + $past(term_prio_unit)])
    else $error("priority terminal bit missing");
  a_count_word: assert property (!terminal_link_mode |=>
    cnt232_word == $past(stat[P232].count))
    else $error("count word not showing count");
  a_restart_req: assert property (restart_set[P232] |=>
    restart_req[P232] && w_restart[B232_RESTART])
    else $error("restart request not raised");
  a_read_answer: assert property (arvalid && arready |=>
    rvalid && rdata == $past(rd_mux))
    else $error("read answer late or wrong");
  a_irq_level: assert property ((|irq_event) |=>
    ((irq_status & $past(irq_event)) == $past(irq_event)))
    else $error("interrupt event not latched");
  a_write_answer: assert property (wr_en |=> bvalid [*1] ##0 !aw_held)
    else $error("write answer missing");

  c_raw_read: cover property (rvalid && !terminal_link_mode
    && rdata[15:0] != 16'h0000);
  c_term_mode: cover property (terminal_link_mode && term_prio_valid);
  c_irq_fire: cover property ($rose(irq));
  c_restart: cover property (restart_set[P422]);

endmodule // spsf_regs

// ### testbench/serial_port_status_flags_test.sv
`timescale 1ns/1ns
module serial_port_status_flags_test
  import spsf_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NPORTS-1:0] restart_req;
  spsf_evt_t evt_232, evt_422;
  logic tmode, prio_v;
  logic [7:0] act;
  logic [2:0] prio_u;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic [1:0] r;

  spsf_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .evt_232(evt_232), .evt_422(evt_422),
    .terminal_link_mode(tmode), .term_active(act),
    .term_prio_valid(prio_v), .term_prio_unit(prio_u),
    .restart_req(restart_req), .irq(irq));

  spsf_dev_model u_dev (.aclk(aclk), .aresetn(aresetn),
    .restart_req(restart_req), .evt_232(evt_232), .evt_422(evt_422));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus master: each channel held until its own handshake edge
  // pending flags are kept locally: the driven signals only change
  // after this time step, so testing them here would see stale values
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    bit aw_p;
    bit w_p;
    bit b_p;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (aw_p || w_p || b_p) begin
      @(posedge aclk);
      if (aw_p && awready) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
      if (b_p && bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        b_p = 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    bit ar_p;
    bit r_p;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    while (ar_p || r_p) begin
      @(posedge aclk);
      if (ar_p && arready) begin
        arvalid <= 1'b0;
        ar_p = 1'b0;
      end
      if (r_p && rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        r_p = 1'b0;
      end
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk($sformatf("word %h", a), e, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // sticky flags, levels and byte count of one port in raw mode
  task automatic t_events(input int p);
    spsf_evt_t e;
    logic [11:0] sa;
    int sh;
    sa = (p != 0) ? 12'h4f8 : 12'h620;
    sh = (p != 0) ? B422_COMM : B232_COMM;
    e = '0;
    e.err = 4'h9;
    e.comm_err = 1'b1;
    e.rx_done = 1'b1;
    e.overflow = 1'b1;
    u_dev.fire(p, e);
    u_dev.levels(p, 1'b1, 1'b1);
    rc(sa, (32'hf << sh) | ((p != 0) ? 32'h8024 : 32'h0));
    if (p == 0) rc(12'h840, 32'h24);
    rc(12'h9ac, (p == 0) ? 32'h4 : 32'h0);
    e = '0;
    e.rx_byte = 1'b1;
    repeat (3) u_dev.fire(p, e);
    rc((p != 0) ? 12'h4fc : 12'h624, 32'h3);
    u_dev.levels(p, 1'b0, 1'b0);
    rc(sa, (32'hd << sh) | ((p != 0) ? 32'h24 : 32'h0));
  endtask

  // counter word follows the mode; bytes in link mode are not counted
  task automatic t_terminal;
    spsf_evt_t e;
    e = '0;
    e.rx_byte = 1'b1;
    tmode <= 1'b1;
    act <= 8'h5a;
    prio_v <= 1'b1;
    prio_u <= 3'd5;
    rc(12'h624, 32'h205a);
    prio_u <= 3'd0;
    u_dev.fire(P232, e);
    rc(12'h624, 32'h015a);
    tmode <= 1'b0;
    rc(12'h624, 32'h3);
  endtask

  // restart bit stays set until the engine reports completion
  task automatic t_restart(input int p, input int unsigned lag);
    logic [31:0] bit_v;
    int n;
    bit_v = (p != 0) ? 32'h80 : 32'h1;
    u_dev.lag[p] = lag;
    wr(12'h838, bit_v, r);
    chk("restart req", {30'h0, (p != 0) ? 2'b10 : 2'b01},
        {30'h0, restart_req});
    if (lag > 10) rc(12'h838, bit_v);
    n = 0;
    d = bit_v;
    while (d != 0 && n < 40) begin
      rd(12'h838, d, r);
      n++;
    end
    chk("restart bit", 32'h0, d);
    rc((p != 0) ? 12'h4fc : 12'h624, 32'h0);
  endtask

  // raise, mask and clear the interrupt
  task automatic t_irq;
    rc(12'hc00, 32'hff);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(12'hc08, 32'hff, r);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(12'hc04, 32'hff, r);
    rc(12'hc00, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {tmode, prio_v, act, prio_u} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(12'h620, 32'h0);
    rc(12'h4f8, 32'h0);
    rc(12'h838, 32'h0);
    rd(12'h100, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(12'h620, 32'hffff, r);
    chk("ro write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rc(12'h620, 32'h0);
    t_events(P232);
    t_events(P422);
    t_terminal;
    t_restart(P232, 20);
    t_restart(P422, 0);
    t_irq;
    test_done;
  end

  // watchdog, far beyond the expected run
  initial begin
    #(50 * 20000);
    miscompares++;
    test_done;
  end
endmodule // serial_port_status_flags_test

// ### testbench/spsf_dev_model.sv
`timescale 1ns/1ns
module spsf_dev_model
  import spsf_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // restart handshake
  input  wire logic [NPORTS-1:0] restart_req,
  // engine outputs
  output spsf_evt_t              evt_232,
  output spsf_evt_t              evt_422
);
  spsf_evt_t         pulse [NPORTS];
  logic [NPORTS-1:0] send;
  logic [NPORTS-1:0] busy;
  logic [NPORTS-1:0] done;
  int unsigned       lag [NPORTS];

  initial begin
    pulse[0] = '0;
    pulse[1] = '0;
    send = '0;
    busy = '0;
    done = '0;
    lag[0] = 0;
    lag[1] = 0;
  end

  // pulses idle low; levels stay until changed
  always_comb begin
    evt_232 = pulse[P232];
    evt_422 = pulse[P422];
    evt_232.send_ready = send[P232];
    evt_422.send_ready = send[P422];
    evt_232.settings_busy = busy[P232];
    evt_422.settings_busy = busy[P422];
    evt_232.restart_done = done[P232];
    evt_422.restart_done = done[P422];
  end

  // one-cycle event pulse, launched after a rising edge
  task automatic fire(input int p, input spsf_evt_t e);
    @(posedge aclk);
    pulse[p] <= e;
    @(posedge aclk);
    pulse[p] <= '0;
  endtask

  task automatic levels(input int p, input logic s, input logic b);
    @(posedge aclk);
    send[p] <= s;
    busy[p] <= b;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // restart engines answer after lag cycles, once per request
  for (genvar g = 0; g < NPORTS; g++) begin : g_rst
    initial begin
      forever begin
        @(posedge aclk);
        if (aresetn && restart_req[g]) begin
          repeat (lag[g]) @(posedge aclk);
          done[g] <= 1'b1;
          @(posedge aclk);
          done[g] <= 1'b0;
        end
      end
    end
  end
endmodule // spsf_dev_model
